// ===== brc_pkg.sv
// Purpose: Controller constants and types
// Assumes: 20 MHz clock, 8-bit codes
// Notes: Offsets and targets in volts
package brc_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int ADC_MAX_CODE = 255;
    // Full scales
    localparam int BATT_FULL_SCALE_V = 40;
    localparam int BOOST_FULL_SCALE_V = 80;
    // Resample intervals
    localparam int BOOST_INT_NS = 17000;
    localparam int BATT_INT_NS = 108000;
    localparam int LED_INT_NS = 52000;
    localparam int TEMP_INT_MS = 4;
    localparam int BOOST_CYC = BOOST_INT_NS / CLK_PERIOD_NS;
    localparam int BATT_CYC = BATT_INT_NS / CLK_PERIOD_NS;
    localparam int LED_CYC = LED_INT_NS / CLK_PERIOD_NS;
    localparam int TEMP_CYC = TEMP_INT_MS * 1000000 / CLK_PERIOD_NS;
    // Period in oscillator edges
    localparam int PWM_STEPS = 64;
    localparam logic [5:0] DUTY_MIN = 6'h04;
    localparam logic [5:0] DUTY_CEIL = 6'h3d;
    // Ranges and windows, volts
    localparam int TARGET_BASE_V = 18;
    localparam int TARGET_STEP_V = 3;
    localparam int WIN0_HALF_V = 1;
    localparam int WIN1_HALF_V = 5;
    localparam int WIN2_HALF_V = 10;
    localparam int SHUTDOWN_OFS_V = 15;
    // Band upper bounds, volts
    localparam int BAND_V [0:6] = '{5, 10, 16, 20, 24, 30, 35};
    localparam logic [5:0] DMAX_BY_BAND [0:7] = '{6'h3d, 6'h3a, 6'h36, 6'h32, 6'h2e, 6'h2a, 6'h26, 6'h22};
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
    localparam logic [31:0] THRESH_RESET = 32'h001e_0ae6;
    localparam int CTRL_RNG_LSB = 0;
    localparam int CTRL_OFF_BIT = 4;
    localparam int CTRL_SEL_LSB = 8;
    localparam int CORR_PERIODS_DEF = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CH_BOOST = 3'h0,
        CH_BATT = 3'h1,
        CH_LED1 = 3'h2,
        CH_LED2 = 3'h3,
        CH_TEMP1 = 3'h4,
        CH_TEMP2 = 3'h5
    } brc_chan_type;

    typedef enum logic [2:0] {
        WIN_0 = 3'h0,
        WIN_1 = 3'h1,
        WIN_2 = 3'h2,
        WIN_3 = 3'h3,
        WIN_SHUT = 3'h4
    } brc_win_type;

    // Volts to nearest code
    function automatic logic [7:0] volts_to_code(input int v, input int fs);
        int c;
        c = (v * ADC_MAX_CODE + fs / 2) / fs;
        if (c > ADC_MAX_CODE) begin
            c = ADC_MAX_CODE;
        end
        return c[7:0];
    endfunction
endpackage

// ===== brc_top.sv
// Purpose: Boost regulation controller
// Assumes: Synchronous oscillator input
// Notes: Registers over AXI4-Lite
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module brc_top #(
    parameter int TEMP_CYC = brc_pkg::TEMP_CYC,
    parameter int CORR_PERIODS = brc_pkg::CORR_PERIODS_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter
    output logic adc_req,
    output logic [2:0] adc_chan,
    input wire logic adc_done,
    input wire logic [7:0] adc_data,
    input wire logic [1:0] led_string_active,
    // Boost stage
    input wire logic booster_reference_oscillator,
    output logic boost_gate_drive,
    // Diagnostics
    output logic [1:0] string_open_flag,
    output logic [1:0] string_short_flag,
    output logic [1:0] string_indirect_short_flag,
    output logic boost_undervoltage_flag
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] thresh;
        logic [5:0][7:0] samp;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic adc_busy;
        logic adc_req;
        logic [2:0] adc_chan;
        logic [5:0] pend;
        logic [8:0] t_boost;
        logic [11:0] t_batt;
        logic [10:0] t_led;
        logic [16:0] t_temp;
        logic osc_prev;
        logic [5:0] phase;
        logic [5:0] duty;
        logic gate;
        logic shut;
        brc_pkg::brc_win_type win;
        logic below;
        logic [3:0] corr_cnt;
        logic lim_tgl;
        logic [1:0] open_f;
        logic [1:0] short_f;
        logic [1:0] ind_f;
        logic uv;
    } brc_state_type;

    brc_state_type s_q;
    brc_state_type s_d;

    // Range target code
    function automatic logic [7:0] target_code(input logic [3:0] rng);
        return brc_pkg::volts_to_code(brc_pkg::TARGET_BASE_V + brc_pkg::TARGET_STEP_V * int'(rng),
            brc_pkg::BOOST_FULL_SCALE_V);
    endfunction

    // Volts offset to counts
    function automatic int boost_ofs(input int v);
        return int'(brc_pkg::volts_to_code(v, brc_pkg::BOOST_FULL_SCALE_V));
    endfunction

    // Battery band of a code
    function automatic logic [2:0] batt_band(input logic [7:0] code);
        logic [2:0] b;
        b = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (code >= brc_pkg::volts_to_code(brc_pkg::BAND_V[i], brc_pkg::BATT_FULL_SCALE_V)) begin
                b = 3'(i + 1);
            end
        end
        return b;
    endfunction

    // Window of a boost sample
    function automatic brc_pkg::brc_win_type classify(input logic [7:0] code, input logic [3:0] rng);
        int d;
        int a;
        d = int'(code) - int'(target_code(rng));
        a = (d < 0) ? -d : d;
        if (d >= boost_ofs(brc_pkg::SHUTDOWN_OFS_V)) begin
            return brc_pkg::WIN_SHUT;
        end else if (a <= boost_ofs(brc_pkg::WIN0_HALF_V)) begin
            return brc_pkg::WIN_0;
        end else if (a <= boost_ofs(brc_pkg::WIN1_HALF_V)) begin
            return brc_pkg::WIN_1;
        end else if (a <= boost_ofs(brc_pkg::WIN2_HALF_V)) begin
            return brc_pkg::WIN_2;
        end else begin
            return brc_pkg::WIN_3;
        end
    endfunction

    // Step and clamp duty
    function automatic logic [5:0] step_duty(input logic [5:0] duty, input logic up, input int amt,
        input logic [5:0] hi);
        int n;
        n = up ? int'(duty) + amt : int'(duty) - amt;
        if (n > int'(hi)) begin
            n = int'(hi);
        end
        if (n < int'(brc_pkg::DUTY_MIN)) begin
            n = int'(brc_pkg::DUTY_MIN);
        end
        return n[5:0];
    endfunction

    // Byte lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [3:0] rng;
    logic [2:0] band;
    logic [5:0] dmax;
    logic osc_edge;
    logic period_end;
    logic [7:0] nreg_low;

    assign rng = s_q.ctrl[brc_pkg::CTRL_RNG_LSB +: 4];
    assign band = batt_band(s_q.samp[brc_pkg::CH_BATT]);
    assign dmax = (brc_pkg::DMAX_BY_BAND[band] > brc_pkg::DUTY_CEIL) ?
        brc_pkg::DUTY_CEIL : brc_pkg::DMAX_BY_BAND[band];
    assign osc_edge = booster_reference_oscillator && !s_q.osc_prev;
    assign period_end = osc_edge && (s_q.phase == 6'(brc_pkg::PWM_STEPS - 1));
    assign nreg_low = 8'(int'(target_code(rng)) - boost_ofs(brc_pkg::WIN1_HALF_V));

    always_comb begin
        logic [31:0] rd;
        logic [1:0] rr;
        s_d = s_q;
        rd = 32'h0000_0000;
        rr = brc_pkg::RESP_OKAY;

        // Address and data in either order
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = brc_pkg::RESP_OKAY;
            if (s_q.aw_addr[7:2] == brc_pkg::OFS_CTRL[7:2]) begin
                s_d.ctrl = merge(s_q.ctrl, s_q.w_data, s_q.w_strb) & 32'h0000_071f;
            end else if (s_q.aw_addr[7:2] == brc_pkg::OFS_THRESH[7:2]) begin
                s_d.thresh = merge(s_q.thresh, s_q.w_data, s_q.w_strb) & 32'h00ff_ffff;
            end else if (s_q.aw_addr[7:2] > brc_pkg::OFS_STATUS[7:2]) begin
                s_d.bresp = brc_pkg::RESP_SLVERR;
            end
        end
        s_d.awready = !s_d.aw_held && !s_d.bvalid;
        s_d.wready = !s_d.w_held && !s_d.bvalid;

        // Read answers in one cycle
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            if (s_axi_araddr[7:2] == brc_pkg::OFS_CTRL[7:2]) begin
                rd = s_q.ctrl;
            end else if (s_axi_araddr[7:2] == brc_pkg::OFS_THRESH[7:2]) begin
                rd = s_q.thresh;
            end else if (s_axi_araddr[7:2] == brc_pkg::OFS_RESULT[7:2]) begin
                // Unused selector codes read zero
                if (s_q.ctrl[brc_pkg::CTRL_SEL_LSB +: 3] <= brc_pkg::CH_TEMP2) begin
                    rd = {24'h00_0000, s_q.samp[s_q.ctrl[brc_pkg::CTRL_SEL_LSB +: 3]]};
                end
            end else if (s_axi_araddr[7:2] == brc_pkg::OFS_STATUS[7:2]) begin
                rd = {8'h00, s_q.ind_f, s_q.short_f, s_q.open_f, s_q.uv, s_q.shut, 1'b0, s_q.win,
                    1'b0, band, 2'h0, s_q.duty};
            end else begin
                rr = brc_pkg::RESP_SLVERR;
            end
            s_d.rvalid = 1'b1;
            s_d.rdata = rd;
            s_d.rresp = rr;
        end
        s_d.arready = !s_d.rvalid;

        // Resample timers
        s_d.adc_req = 1'b0;
        s_d.t_boost = (s_q.t_boost == 9'(brc_pkg::BOOST_CYC - 1)) ? 9'h000 : s_q.t_boost + 9'h001;
        s_d.t_batt = (s_q.t_batt == 12'(brc_pkg::BATT_CYC - 1)) ? 12'h000 : s_q.t_batt + 12'h001;
        s_d.t_led = (s_q.t_led == 11'(brc_pkg::LED_CYC - 1)) ? 11'h000 : s_q.t_led + 11'h001;
        s_d.t_temp = (s_q.t_temp == 17'(TEMP_CYC - 1)) ? 17'h00000 : s_q.t_temp + 17'h00001;

        // Store converter results
        if (s_q.adc_busy && adc_done) begin
            s_d.adc_busy = 1'b0;
            s_d.samp[s_q.adc_chan] = adc_data;
        end
        // Priority: boost, battery, strings, temperature
        if (!s_q.adc_busy) begin
            for (int i = 5; i >= 0; i--) begin
                if (s_q.pend[i]) begin
                    s_d.adc_chan = 3'(i);
                end
            end
            if (s_q.pend != 6'h00) begin
                s_d.adc_busy = 1'b1;
                s_d.adc_req = 1'b1;
                s_d.pend[s_d.adc_chan] = 1'b0;
            end
        end
        // Set wins over clear
        if (s_q.t_boost == 9'(brc_pkg::BOOST_CYC - 1)) begin
            s_d.pend[brc_pkg::CH_BOOST] = 1'b1;
        end
        if (s_q.t_batt == 12'(brc_pkg::BATT_CYC - 1)) begin
            s_d.pend[brc_pkg::CH_BATT] = 1'b1;
        end
        if (s_q.t_led == 11'(brc_pkg::LED_CYC - 1)) begin
            // Unlit strings keep last value
            s_d.pend[brc_pkg::CH_LED1 +: 2] = s_d.pend[brc_pkg::CH_LED1 +: 2] | led_string_active;
        end
        if (s_q.t_temp == 17'(TEMP_CYC - 1)) begin
            s_d.pend[brc_pkg::CH_TEMP1 +: 2] = 2'h3;
        end

        // Fixed period of 64 oscillator edges
        s_d.osc_prev = booster_reference_oscillator;
        if (osc_edge) begin
            s_d.phase = s_q.phase + 6'h01;
        end

        // Latest boost window
        s_d.win = classify(s_q.samp[brc_pkg::CH_BOOST], rng);
        s_d.below = s_q.samp[brc_pkg::CH_BOOST] < target_code(rng);
        s_d.uv = s_q.samp[brc_pkg::CH_BOOST] < nreg_low;
        s_d.shut = (s_q.win == brc_pkg::WIN_SHUT);

        // Once per switching period
        if (period_end) begin
            s_d.lim_tgl = !s_q.lim_tgl;
            s_d.corr_cnt = (s_q.corr_cnt == 4'(CORR_PERIODS - 1)) ? 4'h0 : s_q.corr_cnt + 4'h1;
            if (s_q.duty < brc_pkg::DUTY_MIN) begin
                // Restart at floor
                s_d.duty = brc_pkg::DUTY_MIN;
            end else begin
                case (s_q.win)
                    brc_pkg::WIN_0: begin
                        s_d.duty = s_q.duty;
                    end
                    brc_pkg::WIN_1: begin
                        if (s_q.corr_cnt == 4'(CORR_PERIODS - 1)) begin
                            s_d.duty = step_duty(s_q.duty, s_q.below, 1, dmax);
                        end
                    end
                    brc_pkg::WIN_2: begin
                        if (s_q.corr_cnt == 4'(CORR_PERIODS - 1)) begin
                            s_d.duty = step_duty(s_q.duty, s_q.below, 2, dmax);
                        end
                    end
                    brc_pkg::WIN_3: begin
                        // Every other period, faster than cadence only when CORR_PERIODS exceeds 2
                        if (s_q.lim_tgl) begin
                            s_d.duty = step_duty(s_q.duty, s_q.below, 2, dmax);
                        end
                    end
                    default: begin
                        s_d.duty = s_q.duty;
                    end
                endcase
            end
            // Rising band may pull ceiling below duty
            if (s_d.duty > dmax) begin
                s_d.duty = dmax;
            end
        end
        if (s_d.shut || s_q.ctrl[brc_pkg::CTRL_OFF_BIT]) begin
            s_d.duty = 6'h00;
        end
        // Duty stays below 63, so the gate drops
        s_d.gate = (s_d.phase < s_d.duty) && !s_d.shut && !s_q.ctrl[brc_pkg::CTRL_OFF_BIT];

        // String checks
        for (int i = 0; i < 2; i++) begin
            s_d.open_f[i] = s_q.samp[2 + i] >= s_q.thresh[7:0];
            s_d.short_f[i] = s_q.samp[2 + i] <= s_q.thresh[15:8];
            s_d.ind_f[i] = (s_q.samp[2 + i] <= s_q.thresh[23:16]) && !s_d.short_f[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.ctrl <= brc_pkg::CTRL_RESET;
            s_q.thresh <= brc_pkg::THRESH_RESET;
            s_q.win <= brc_pkg::WIN_0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign adc_req = s_q.adc_req;
    assign adc_chan = s_q.adc_chan;
    assign boost_gate_drive = s_q.gate;
    assign string_open_flag = s_q.open_f;
    assign string_short_flag = s_q.short_f;
    assign string_indirect_short_flag = s_q.ind_f;
    assign boost_undervoltage_flag = s_q.uv;
endmodule
`default_nettype wire

// ===== brc_top_monitor.sv
// Purpose: Port checks for the controller
// Assumes: Oscillator sampled on aclk
// Notes: Bound into brc_top
`timescale 1ns/100ps
`default_nettype none
module brc_top_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Converter and boost stage
    input wire logic adc_req,
    input wire logic [2:0] adc_chan,
    input wire logic adc_done,
    input wire logic booster_reference_oscillator,
    input wire logic boost_gate_drive
);
    logic busy_q;
    logic osc_q;
    logic [6:0] hi_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Edges per on-time; full on reaches 63
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            osc_q <= 1'b0;
            hi_q <= 7'h00;
        end else begin
            osc_q <= booster_reference_oscillator;
            if (adc_req) busy_q <= 1'b1;
            else if (adc_done) busy_q <= 1'b0;
            if (!boost_gate_drive) hi_q <= 7'h00;
            else if (booster_reference_oscillator && !osc_q && hi_q != 7'h7f) hi_q <= hi_q + 7'h01;
        end
    end
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_FULL_ON_NEVER: assert property (hi_q < 7'h3f)
        else $error("gate held on for a full period");
    AST_REQ_PULSE: assert property (adc_req |=> !adc_req)
        else $error("request longer than one cycle");
    AST_REQ_IDLE: assert property (adc_req |-> !busy_q)
        else $error("request while busy");
    AST_CHAN_LEGAL: assert property (adc_req |-> adc_chan <= 3'h5)
        else $error("request on unused channel");
    AST_CHAN_HOLD: assert property (!adc_req |-> $stable(adc_chan))
        else $error("channel moved without a request");
    AST_WR_ANSWER: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind brc_top brc_top_monitor mon (.*);
`default_nettype wire

// ===== brc_stage_model.sv
// Purpose: Converter and oscillator model
// Assumes: One conversion at a time
// Notes: Data toggles outside answers
`timescale 1ns/100ps
`default_nettype none
module brc_stage_model (
    // Clock
    input wire logic aclk,
    // Converter
    input wire logic adc_req,
    input wire logic [2:0] adc_chan,
    output logic adc_done,
    output logic [7:0] adc_data,
    // Boost stage
    output logic booster_reference_oscillator,
    input wire logic boost_gate_drive
);
    logic [7:0] codes [0:7];
    logic [2:0] chan_q;
    int dly = 1;
    int cnt = -1;
    initial begin
        adc_done = 1'b0;
        adc_data = 8'h00;
        booster_reference_oscillator = 1'b0;
        chan_q = 3'h0;
        for (int i = 0; i < 8; i++) codes[i] = 8'h00;
    end
    // Free-running, two clocks per cycle
    always @(posedge aclk) booster_reference_oscillator <= ~booster_reference_oscillator;
    always @(posedge aclk) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (adc_req) begin
            chan_q <= adc_chan;
            cnt <= dly;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            // Bench codes are already scaled
            adc_done <= 1'b1;
            adc_data <= codes[chan_q];
            cnt <= -1;
        end
    end
endmodule
`default_nettype wire

// ===== tb_brc_top.sv
// Purpose: Self-checking bench
// Assumes: Stage model answers the converter
// Notes: Short counts keep the run brief
`timescale 1ns/100ps
`default_nettype none
module tb_brc_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, adc_req, adc_done;
    logic booster_reference_oscillator, boost_gate_drive, boost_undervoltage_flag;
    logic [7:0] s_axi_awaddr, s_axi_araddr, adc_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [2:0] adc_chan;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, led_string_active, string_open_flag, string_short_flag;
    logic [1:0] string_indirect_short_flag;
    int num_errors, total_checks;
    brc_top #(.TEMP_CYC(200), .CORR_PERIODS(2)) dut (.*);
    brc_stage_model model (.*);
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_regs();
        rdr(8'h00);
        check("ctrl reset", rd, 32'h0000_0006);
        rdr(8'h04);
        check("thresh reset", rd, 32'h001e_0ae6);
        rdr(8'h10);
        check("unmapped resp", 32'(rsp), 32'h2);
        check("unmapped data", rd, 32'h0);
        wr(8'h10, 32'h0);
        check("unmapped wresp", 32'(rsp), 32'h2);
        $display("test regs done");
    endtask
    task automatic t_select();
        logic [7:0] c [0:7] = '{8'h73, 8'h10, 8'h40, 8'h50, 8'h21, 8'h9a, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) model.codes[i] <= c[i];
        // Range 6 sits above the string codes used here
        repeat (2300) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, {21'h0, i[2:0], 8'h06});
            rdr(8'h08);
            check("result", rd, {24'h0, c[i]});
        end
        $display("test select done");
    endtask
    task automatic t_diag();
        model.codes[2] <= 8'he6;
        model.codes[3] <= 8'h0a;
        repeat (2500) @(posedge aclk);
        check("open", 32'(string_open_flag), 32'h1);
        check("short", 32'(string_short_flag), 32'h2);
        check("indirect", 32'(string_indirect_short_flag), 32'h0);
        model.codes[2] <= 8'h0b;
        model.codes[3] <= 8'h1f;
        repeat (2500) @(posedge aclk);
        check("open", 32'(string_open_flag), 32'h0);
        check("short", 32'(string_short_flag), 32'h0);
        check("indirect", 32'(string_indirect_short_flag), 32'h1);
        $display("test diag done");
    endtask
    task automatic t_bands();
        logic [7:0] c [0:7] = '{8'h10, 8'h30, 8'h50, 8'h73, 8'h8c, 8'haa, 8'hcf, 8'hf0};
        model.dly = 6;
        for (int b = 0; b < 8; b++) begin
            model.codes[1] <= c[b];
            repeat (2300) @(posedge aclk);
            rdr(8'h0c);
            check("band", 32'(rd[10:8]), b);
        end
        model.dly = 1;
        $display("test bands done");
    endtask
    task automatic t_windows();
        logic [7:0] c [0:11] = '{8'h73, 8'h76, 8'h77, 8'h7d, 8'h8c, 8'h9b, 8'ha2, 8'ha3, 8'h63, 8'h62, 8'h53, 8'h52};
        logic [2:0] w [0:11] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h1, 3'h2, 3'h2, 3'h3};
        for (int i = 0; i < 12; i++) begin
            model.codes[0] <= c[i];
            repeat (700) @(posedge aclk);
            rdr(8'h0c);
            check("window", 32'(rd[14:12]), 32'(w[i]));
            check("shutdown", 32'(rd[16]), 32'(w[i] == 3'h4));
            check("undervolt", 32'(boost_undervoltage_flag), 32'(c[i] < 8'h63));
            if (w[i] == 3'h4) check("shut duty", 32'(rd[5:0]), 32'h0);
        end
        $display("test windows done");
    endtask
    task automatic t_ranges();
        for (int r = 0; r < 16; r++) begin
            wr(8'h00, r);
            model.codes[0] <= 8'(((18 + 3 * r) * 255 + 40) / 80);
            repeat (700) @(posedge aclk);
            rdr(8'h0c);
            check("range target", 32'(rd[14:12]), 32'h0);
        end
        wr(8'h00, 32'h6);
        $display("test ranges done");
    endtask
    task automatic t_limits();
        model.codes[1] <= 8'h10;
        model.codes[0] <= 8'h46;
        repeat (9000) @(posedge aclk);
        rdr(8'h0c);
        check("max band 0", 32'(rd[5:0]), 32'h3d);
        model.codes[1] <= 8'hf0;
        repeat (3000) @(posedge aclk);
        rdr(8'h0c);
        check("max band 7", 32'(rd[5:0]), 32'h22);
        model.codes[0] <= 8'h8c;
        repeat (5000) @(posedge aclk);
        rdr(8'h0c);
        check("min duty", 32'(rd[5:0]), 32'h4);
        $display("test limits done");
    endtask
    task automatic t_step(input logic [7:0] code, input int step);
        int prev;
        int diff;
        int moved = 0;
        model.codes[0] <= code;
        repeat (400) @(posedge aclk);
        rdr(8'h0c);
        prev = rd[5:0];
        // Faster sampling than cadence sees single steps
        for (int i = 0; i < 12; i++) begin
            repeat (64) @(posedge aclk);
            rdr(8'h0c);
            diff = int'(rd[5:0]) - prev;
            check("step", 32'(diff == 0 || diff == step), 32'h1);
            moved += (diff != 0);
            prev = rd[5:0];
        end
        check("cadence", 32'(moved > 0 && moved < 5), 32'(step != 0));
        $display("test step %0d done", step);
    endtask
    task automatic t_pwm();
        int hi = 0;
        model.codes[0] <= 8'h73;
        repeat (600) @(posedge aclk);
        rdr(8'h0c);
        while (boost_gate_drive !== 1'b0) @(posedge aclk);
        while (boost_gate_drive !== 1'b1) @(posedge aclk);
        repeat (127) begin
            hi += boost_gate_drive;
            @(posedge aclk);
        end
        check("off at period end", 32'(boost_gate_drive), 32'h0);
        @(posedge aclk);
        check("period start", 32'(boost_gate_drive), 32'h1);
        check("on time", hi, {25'h0, rd[5:0], 1'b0});
        $display("test pwm done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (95000) @(posedge aclk);
        num_errors++;
        complete_run();
    end
    initial begin
        num_errors = 0;
        total_checks = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        led_string_active = 2'h3;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_select();
        t_diag();
        t_bands();
        t_windows();
        t_ranges();
        t_limits();
        t_step(8'h69, 1);
        t_step(8'h5a, 2);
        t_step(8'h73, 0);
        t_step(8'h8c, -2);
        t_step(8'h7d, -1);
        t_pwm();
        complete_run();
    end
endmodule
`default_nettype wire
